// >>> core_flow_pkg.sv
// shared constants, types and decode functions of the program-flow block
package core_flow_pkg;

    localparam int PC_WIDTH    = 10;
    localparam int STACK_WIDTH = 12;
    localparam int FILE_AWIDTH = 5;

    // register file addresses
    localparam logic [4:0] INDIRECT_ADDR = 5'h00;
    localparam logic [4:0] PCL_ADDR      = 5'h02;
    localparam logic [4:0] STATUS_ADDR   = 5'h03;
    localparam logic [4:0] POINTER_ADDR  = 5'h04;
    localparam logic [4:0] TRIM_ADDR     = 5'h05;

    // field positions
    localparam int OPT_WAKE_BIT    = 7;
    localparam int OPT_PULLUP_BIT  = 6;
    localparam int OPT_SOURCE_BIT  = 5;
    localparam int OPT_EDGE_BIT    = 4;
    localparam int OPT_ASSIGN_BIT  = 3;
    localparam int OPT_RATE_LSB    = 0;
    localparam int STATUS_PAGE_BIT = 5;
    localparam int POINTER_BANK_BIT = 5;

    // values after reset, and fixed read values of the pointer high bits and the self-pointing read
    localparam logic [PC_WIDTH-1:0] PC_RESET      = 10'h3ff;
    localparam logic [7:0]          OPTION_RESET  = 8'hff;
    localparam logic [6:0]          TRIM_RESET    = 7'h7f;
    localparam logic [5:0]          POINTER_RESET = 6'h00;
    localparam logic                PAGE_RESET    = 1'b0;
    localparam logic [1:0]          POINTER_HIGH  = 2'h3;
    localparam logic [7:0]          NULL_READ     = 8'h00;
    localparam logic [STACK_WIDTH-1:0] STACK_RESET = 12'h000;

    typedef struct packed {
        logic                   jump;
        logic                   call;
        logic                   literalReturn;
        logic                   optionLoad;
        logic                   fileWrite;
        logic                   fileRead;
        logic [FILE_AWIDTH-1:0] fileAddr;
        logic [7:0]             fileData;
        logic [8:0]             instrField;
        logic [7:0]             wValue;
    } core_ctrl_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [5:0] addr;
        logic [7:0] data;
    } mem_access_t;

    typedef struct packed {
        logic       wakeEnable;
        logic       pullupEnable;
        logic       externalSource;
        logic       fallingEdge;
        logic       prescalerToWatchdog;
        logic [2:0] rate;
        logic [8:0] timerDivisor;
        logic [7:0] watchdogDivisor;
        logic       countPulse;
    } timer_cfg_t;

    function automatic logic [8:0] timer_divisor(input logic [2:0] rate);
        return 9'h002 << rate;
    endfunction

    function automatic logic [7:0] watchdog_divisor(input logic [2:0] rate);
        return 8'h01 << rate;
    endfunction

endpackage

// >>> core_pc_stack_and_control_regs.sv
// program counter, return stack, pointer, trim and option control of the core
//
// Summary of operation
// RULE1 - wake-on-change and weak pull-up enables are active low option bits 7, 6.
// RULE2 - option bit 5 picks timer source: 1 external pin, 0 instruction cycles.
// RULE3 - option bit 4 picks pin edge: 1 falling, 0 rising.
// RULE4 - option bit 3 gives prescaler to watchdog when 1, to timer when 0.
// RULE5 - rate field divides timer by 2 to 256, watchdog by 1 to 128.
// RULE6 - option is write-only, loaded from W, all ones after reset.
// RULE7 - trim holds 7-bit two's complement in bits 7:1; bit 0 reads zero.
// RULE8 - program counter increments every cycle unless an instruction loads it.
// RULE9 - jump loads bits 8:0 from instruction, bit 9 from page preselect.
// RULE10 - call or low-byte write loads bits 7:0 and clears bit 8.
// RULE11 - reset sets counter to all ones; next instruction wraps it to zero.
// RULE12 - reset clears page preselect so jumps land in page 0.
// RULE13 - two-level 12-bit return stack reached only by call and return.
// RULE14 - call copies level 1 to level 2, then pushes counter plus one.
// RULE15 - return pops level 1 into counter, copies level 2, loads W literal.
// RULE16 - indirect location accesses the register the pointer addresses.
// RULE17 - pointer at indirect location: read gives 00h, write does nothing.
// RULE18 - pointer bits 4:0 pick address, bit 5 picks bank.
// RULE19 - pointer bits 7:6 are absent and read as binary 11.
`timescale 1ns/1ns
module core_pc_stack_and_control_regs (
    input  wire logic                              ref_clk,
    input  wire logic                              srst,
    input  core_flow_pkg::core_ctrl_t              ctrl,
    input  wire logic                              externalTimerClockPin,
    output logic [core_flow_pkg::PC_WIDTH-1:0]     programCounter,
    output logic                                   pagePreselect,
    output core_flow_pkg::mem_access_t             memAccess,
    output logic [7:0]                             readData,
    output logic                                   readHit,
    output logic                                   wLoad,
    output logic [7:0]                             wLiteral,
    output logic signed [6:0]                      oscillatorTrim,
    output core_flow_pkg::timer_cfg_t              timerCfg,
    output logic [core_flow_pkg::STACK_WIDTH-1:0]  stackLevel1,
    output logic [core_flow_pkg::STACK_WIDTH-1:0]  stackLevel2
);
    import core_flow_pkg::*;

    typedef struct packed {
        logic [PC_WIDTH-1:0] pc;
        logic                page;
        logic [5:0]          pointer;
        logic [6:0]          trim;
        mem_access_t         mem;
        logic [7:0]          readData;
        logic                readHit;
        logic                wLoad;
        logic [7:0]          wLiteral;
    } flow_state_t;

    flow_state_t st;
    flow_state_t next_st;

    logic                   indirect;
    logic                   nullAccess;
    logic [FILE_AWIDTH-1:0] effAddr;
    logic                   pclWritten;
    logic                   internalReg;
    logic                   push;
    logic                   pop;
    logic [STACK_WIDTH-1:0] pushValue;
    logic [STACK_WIDTH-1:0] level1;
    logic [STACK_WIDTH-1:0] level2;
    logic [PC_WIDTH-1:0]    pcPlusOne;

    // stack is only touched here, never through the register file
    assign push      = ctrl.call && !ctrl.literalReturn;             // see RULE13
    assign pop       = ctrl.literalReturn;                           // see RULE13
    assign pcPlusOne = st.pc + 10'h001;
    assign pushValue = {{(STACK_WIDTH - PC_WIDTH){1'b0}}, pcPlusOne}; // see RULE14

    return_stack u_stack (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .push      (push),
        .pop       (pop),
        .pushValue (pushValue),
        .level1    (level1),
        .level2    (level2)
    );

    timer_option_ctrl u_option (
        .ref_clk               (ref_clk),
        .srst                  (srst),
        .load                  (ctrl.optionLoad),                    // see RULE6
        .value                 (ctrl.wValue),
        .externalTimerClockPin (externalTimerClockPin),
        .cfg                   (timerCfg)
    );

    always_comb begin
        next_st = st;
        next_st.wLoad      = 1'b0;
        next_st.readHit    = 1'b0;
        next_st.readData   = 8'h00;
        next_st.mem.read   = 1'b0;
        next_st.mem.write  = 1'b0;

        // the indirect location has no storage; it names the pointed-to register
        indirect   = (ctrl.fileAddr == INDIRECT_ADDR);               // see RULE16
        nullAccess = indirect && (st.pointer[4:0] == INDIRECT_ADDR); // see RULE17
        effAddr    = indirect ? st.pointer[4:0] : ctrl.fileAddr;     // see RULE16
        pclWritten = ctrl.fileWrite && !nullAccess && (effAddr == PCL_ADDR);
        internalReg = (effAddr == PCL_ADDR) || (effAddr == POINTER_ADDR)
                   || (effAddr == TRIM_ADDR);

        // program counter load, in priority order
        if (ctrl.literalReturn) begin
            next_st.pc       = level1[PC_WIDTH-1:0];                 // see RULE15
            next_st.wLoad    = 1'b1;                                 // see RULE15
            next_st.wLiteral = ctrl.instrField[7:0];                 // see RULE15
        end else if (ctrl.call) begin
            // subroutines can only start in the low half of a page
            next_st.pc = {st.page, 1'b0, ctrl.instrField[7:0]};      // see RULE10
        end else if (ctrl.jump) begin
            next_st.pc = {st.page, ctrl.instrField};                 // see RULE9
        end else if (pclWritten) begin
            next_st.pc = {st.page, 1'b0, ctrl.fileData};             // see RULE10
        end else begin
            // all ones rolls over to zero, leaving reset at the top of memory
            next_st.pc = pcPlusOne;                                  // see RULE8 RULE11
        end

        // bank comes from the pointer for both direct and indirect access
        next_st.mem.addr = {st.pointer[POINTER_BANK_BIT], effAddr};  // see RULE18
        next_st.mem.data = ctrl.fileData;

        if (ctrl.fileWrite && !nullAccess) begin                     // see RULE17
            unique case (effAddr)
                STATUS_ADDR: begin
                    next_st.page      = ctrl.fileData[STATUS_PAGE_BIT];
                    // flags live in the datapath, so the write still goes out
                    next_st.mem.write = 1'b1;
                end
                POINTER_ADDR: begin
                    next_st.pointer = ctrl.fileData[5:0];            // see RULE18
                end
                TRIM_ADDR: begin
                    next_st.trim = ctrl.fileData[7:1];               // see RULE7
                end
                PCL_ADDR: begin
                end
                default: begin
                    next_st.mem.write = 1'b1;                        // see RULE16
                end
            endcase
        end

        if (ctrl.fileRead) begin
            if (nullAccess) begin
                next_st.readHit  = 1'b1;
                next_st.readData = NULL_READ;                        // see RULE17
            end else if (internalReg) begin
                next_st.readHit = 1'b1;
                unique case (effAddr)
                    PCL_ADDR:     next_st.readData = st.pc[7:0];
                    POINTER_ADDR: next_st.readData = {POINTER_HIGH, st.pointer}; // see RULE19
                    TRIM_ADDR:    next_st.readData = {st.trim, 1'b0};            // see RULE7
                    default:      next_st.readData = 8'h00;
                endcase
            end else begin
                next_st.mem.read = 1'b1;                             // see RULE16
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '{pc: PC_RESET, page: PAGE_RESET, pointer: POINTER_RESET,  // see RULE11 RULE12
                    trim: TRIM_RESET,
                    mem: '{read: 1'b0, write: 1'b0, addr: 6'h00, data: 8'h00},
                    readData: 8'h00, readHit: 1'b0, wLoad: 1'b0, wLiteral: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign programCounter = st.pc;
    assign pagePreselect  = st.page;
    assign memAccess      = st.mem;
    assign readData       = st.readData;
    assign readHit        = st.readHit;
    assign wLoad          = st.wLoad;
    assign wLiteral       = st.wLiteral;
    assign oscillatorTrim = st.trim;
    assign stackLevel1    = level1;
    assign stackLevel2    = level2;

    // checks

    logic quiet;
    assign quiet = !ctrl.jump && !ctrl.call && !ctrl.literalReturn && !pclWritten;

    property p_advance;
        @(posedge ref_clk) disable iff (srst)
        quiet |=> st.pc == $past(st.pc) + 10'h001;
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance"); // see RULE8

    property p_jump;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.jump && !ctrl.call && !ctrl.literalReturn)
            |=> st.pc == {$past(st.page), $past(ctrl.instrField)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong"); // see RULE9

    property p_call;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.call && !ctrl.literalReturn)
            |=> !st.pc[8] && (st.pc[7:0] == $past(ctrl.instrField[7:0]))
                && (level1 == {2'h0, $past(st.pc) + 10'h001});
    endproperty
    a_call: assert property (p_call) else $error("call load wrong"); // see RULE10

    sequence s_releaseQuiet;
        srst ##1 (!srst && quiet);
    endsequence

    property p_resetWrap;
        @(posedge ref_clk)
        s_releaseQuiet |-> (st.pc == PC_RESET) ##1 (st.pc == 10'h000);
    endproperty
    a_resetWrap: assert property (p_resetWrap) else $error("reset vector did not wrap"); // see RULE11

    property p_page;
        @(posedge ref_clk)
        srst |=> !st.page;
    endproperty
    a_page: assert property (p_page) else $error("page not cleared by reset"); // see RULE12

    property p_return;
        @(posedge ref_clk) disable iff (srst)
        ctrl.literalReturn |=> (st.pc == $past(level1[PC_WIDTH-1:0])) && wLoad
                               && (wLiteral == $past(ctrl.instrField[7:0]));
    endproperty
    a_return: assert property (p_return) else $error("return did not pop and load W"); // see RULE15

    property p_indirect;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.fileWrite && indirect && !nullAccess && !internalReg
            && (st.pointer[4:0] != STATUS_ADDR))
            |=> memAccess.write && (memAccess.addr == $past(st.pointer));
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect write misrouted"); // see RULE16 RULE18

    property p_null;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.fileRead && nullAccess)
            |=> readHit && (readData == NULL_READ) && !memAccess.write && !memAccess.read;
    endproperty
    a_null: assert property (p_null) else $error("self-pointing access not null"); // see RULE17

    property p_pointerRead;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.fileRead && !indirect && (ctrl.fileAddr == POINTER_ADDR))
            |=> readHit && (readData[7:6] == 2'h3);
    endproperty
    a_pointerRead: assert property (p_pointerRead) else $error("pointer high bits not 11"); // see RULE19

    property p_trim;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.fileWrite && !indirect && (ctrl.fileAddr == TRIM_ADDR))
            ##1 !ctrl.fileWrite
            ##1 (ctrl.fileRead && !indirect && (ctrl.fileAddr == TRIM_ADDR))
            |=> readData == {$past(ctrl.fileData, 3) & 8'hfe};
    endproperty
    a_trim: assert property (p_trim) else $error("trim readback wrong"); // see RULE7

    property p_pclWrite;
        @(posedge ref_clk) disable iff (srst)
        (pclWritten && !ctrl.jump && !ctrl.call && !ctrl.literalReturn)
            |=> st.pc == {$past(st.page), 1'b0, $past(ctrl.fileData)};
    endproperty
    a_pclWrite: assert property (p_pclWrite) else $error("low byte write load wrong"); // see RULE10

    property p_nullWrite;
        @(posedge ref_clk) disable iff (srst)
        (ctrl.fileWrite && nullAccess)
            |=> !memAccess.write && $stable(st.pointer) && $stable(st.trim) && $stable(st.page);
    endproperty
    a_nullWrite: assert property (p_nullWrite) else $error("self-pointing write changed state"); // see RULE17

endmodule // core_pc_stack_and_control_regs

// >>> decoder_model.sv
// decoder and datapath stand-in that presents one request per call
`timescale 1ns/1ns
module decoder_model (
    input  wire logic                 ref_clk,
    output core_flow_pkg::core_ctrl_t ctrl
);
    import core_flow_pkg::*;
    initial ctrl = '0;
    // one idle edge before each request leaves an idle cycle between requests; each request is held for one edge
    task automatic issue(input core_ctrl_t req);
        @(posedge ref_clk);
        ctrl <= req;
        @(posedge ref_clk);
        ctrl <= '0;
        #1;
    endtask
endmodule // decoder_model

// >>> return_stack.sv
// two-level return address stack
`timescale 1ns/1ns
module return_stack (
    input  wire logic                                ref_clk,
    input  wire logic                                srst,
    input  wire logic                                push,
    input  wire logic                                pop,
    input  wire logic [core_flow_pkg::STACK_WIDTH-1:0] pushValue,
    output logic      [core_flow_pkg::STACK_WIDTH-1:0] level1,
    output logic      [core_flow_pkg::STACK_WIDTH-1:0] level2
);
    import core_flow_pkg::*;

    typedef struct packed {
        logic [STACK_WIDTH-1:0] level1;
        logic [STACK_WIDTH-1:0] level2;
    } stack_state_t;

    stack_state_t st;
    stack_state_t next_st;

    always_comb begin
        next_st = st;
        if (push) begin
            // oldest entry falls off, no overflow flag
            next_st.level2 = st.level1;                              // see RULE14
            next_st.level1 = pushValue;                              // see RULE14
        end else if (pop) begin
            // level 2 is left as is, so repeated pops keep returning it
            next_st.level1 = st.level2;                              // see RULE15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '{level1: STACK_RESET, level2: STACK_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign level1 = st.level1;
    assign level2 = st.level2;

    property p_push;
        @(posedge ref_clk) disable iff (srst)
        push |=> (st.level1 == $past(pushValue)) && (st.level2 == $past(st.level1));
    endproperty
    a_push: assert property (p_push) else $error("push did not shift the stack"); // see RULE14

    property p_pop;
        @(posedge ref_clk) disable iff (srst)
        (pop && !push) |=> (st.level1 == $past(st.level2)) && $stable(st.level2);
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not copy level 2 into level 1"); // see RULE15

endmodule // return_stack

// >>> tb.sv
// self-checking bench for the program-flow and control register block
`timescale 1ns/1ns
module tb;
    import core_flow_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic pin = 1'b0;
    core_ctrl_t ctrl;
    logic [9:0] pc, expPc;
    logic page, expPage = 1'b0, readHit, wLoad;
    logic [7:0] readData, wLiteral;
    logic signed [6:0] trim;
    mem_access_t mem;
    timer_cfg_t cfg;
    logic [11:0] l1, l2, expL1 = '0, expL2 = '0;
    int mismatches = 0;
    int numChecks = 0;

    always #20 ref_clk = ~ref_clk;

    decoder_model dec_u (.ref_clk(ref_clk), .ctrl(ctrl));
    core_pc_stack_and_control_regs dut_u (.ref_clk(ref_clk), .srst(srst), .ctrl(ctrl),
        .externalTimerClockPin(pin), .programCounter(pc), .pagePreselect(page),
        .memAccess(mem), .readData(readData), .readHit(readHit), .wLoad(wLoad),
        .wLiteral(wLiteral), .oscillatorTrim(trim), .timerCfg(cfg),
        .stackLevel1(l1), .stackLevel2(l2));

    task automatic close_out();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        numChecks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cfg(input logic [7:0] v);
        chk("cfg", {~v[7], ~v[6], v[5], v[4], v[3], v[2:0]}, {cfg.wakeEnable,
            cfg.pullupEnable, cfg.externalSource, cfg.fallingEdge,
            cfg.prescalerToWatchdog, cfg.rate});
        chk("tdiv", 12'h002 << v[2:0], cfg.timerDivisor);
        chk("wdiv", 12'h001 << v[2:0], cfg.watchdogDivisor);
    endtask

    // kinds: 0 jump, 1 call, 2 return, 3 option load, 4 write, 5 read
    task automatic run(input int k, input logic [4:0] a, input logic [8:0] f);
        core_ctrl_t r;
        logic [9:0] nxt;
        r = '0;
        r.jump = (k == 0);
        r.call = (k == 1);
        r.literalReturn = (k == 2);
        r.optionLoad = (k == 3);
        r.fileWrite = (k == 4);
        r.fileRead = (k == 5);
        r.fileAddr = a;
        r.fileData = f[7:0];
        r.wValue = f[7:0];
        r.instrField = f;
        // the idle edge before the request also advances the counter
        expPc = expPc + 10'h001;
        nxt = expPc + 10'h001;
        if (k == 0) nxt = {expPage, f};
        if (k == 1 || (k == 4 && a == PCL_ADDR)) nxt = {expPage, 1'b0, f[7:0]};
        if (k == 1) begin
            expL2 = expL1;
            expL1 = {2'b00, expPc + 10'h001};
        end
        if (k == 2) begin
            nxt = expL1[9:0];
            expL1 = expL2;
        end
        if (k == 4 && a == STATUS_ADDR) expPage = f[5];
        expPc = nxt;
        dec_u.issue(r);
        chk("pc", expPc, pc);
        chk("page", expPage, page);
        chk("level1", expL1, l1);
        chk("level2", expL2, l2);
    endtask

    task automatic s_reset();
        repeat (8) @(posedge ref_clk);
        #1;
        chk("pc", 12'h3ff, pc);
        chk("page", 12'h000, page);
        chk("trim", 12'h07f, {5'h00, trim});
        chk_cfg(8'hff);
        @(posedge ref_clk);
        srst <= 1'b0;
        expPc = 10'h3ff;
    endtask

    task automatic s_option();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = i[0] ? (8'hf8 | i[7:0]) : i[7:0];
            run(3, 5'h00, {1'b0, v});
            chk_cfg(v);
        end
    endtask

    task automatic s_stack();
        run(1, 5'h00, 9'h045);
        run(1, 5'h00, 9'h067);
        run(1, 5'h00, 9'h089);
        for (int i = 1; i < 4; i++) begin
            run(2, 5'h00, {1'b0, i[3:0], 4'h2});
            chk("wLoad", 12'h001, wLoad);
            chk("wLiteral", {i[3:0], 4'h2}, wLiteral);
        end
    endtask

    task automatic s_pointer();
        run(4, POINTER_ADDR, 9'h02a);
        run(5, POINTER_ADDR, 9'h000);
        chk("ptr", 12'h1ea, {readHit, readData});
        run(4, INDIRECT_ADDR, 9'h055);
        chk("ind", 12'h06a, {mem.write, mem.addr});
        chk("inddata", 12'h055, mem.data);
        run(5, INDIRECT_ADDR, 9'h000);
        chk("indrd", 12'h0aa, {mem.read, readHit, mem.addr});
        run(4, POINTER_ADDR, 9'h000);
        run(5, INDIRECT_ADDR, 9'h000);
        chk("nullrd", 12'h100, {readHit, readData});
        run(4, INDIRECT_ADDR, 9'h077);
        chk("nullwr", 12'h000, mem.write);
    endtask

    task automatic s_trim();
        run(4, TRIM_ADDR, 9'h081);
        run(5, TRIM_ADDR, 9'h000);
        chk("trimrd", 12'h180, {readHit, readData});
        chk("trim", 12'h040, {5'h00, trim});
    endtask

    // a pin change reaches the tick three edges late: two sync stages and the edge detect
    task automatic s_pin();
        logic [7:0] v;
        for (int m = 0; m < 2; m++) begin
            v = m[0] ? 8'h20 : 8'h30;
            run(3, 5'h00, {1'b0, v});
            chk_cfg(v);
            for (int e = 0; e < 2; e++) begin
                @(posedge ref_clk);
                pin <= ~pin;
                repeat (2) @(posedge ref_clk);
                #1;
                chk("tick0", 12'h000, cfg.countPulse);
                @(posedge ref_clk);
                #1;
                chk("tick", {11'h000, pin == m[0]}, cfg.countPulse);
            end
            expPc = expPc + 10'h008;
        end
    endtask

    initial begin
        s_reset();
        s_option();
        s_pin();
        run(0, 5'h00, 9'h1a5);
        run(4, STATUS_ADDR, 9'h020);
        run(0, 5'h00, 9'h0f0);
        run(4, PCL_ADDR, 9'h09c);
        s_stack();
        s_pointer();
        s_trim();
        close_out();
    end

    initial begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule // tb

// >>> timer_option_ctrl.sv
// write-only timer and watchdog option register with count-source decode
`timescale 1ns/1ns
module timer_option_ctrl (
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      load,
    input  wire logic [7:0]                value,
    input  wire logic                      externalTimerClockPin,
    output core_flow_pkg::timer_cfg_t      cfg
);
    import core_flow_pkg::*;

    typedef struct packed {
        logic [7:0] option;
        logic [1:0] sync;
        logic       prev;
        timer_cfg_t cfg;
    } option_state_t;

    option_state_t st;
    option_state_t next_st;
    logic          pinEdge;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.option = value;                                  // see RULE6
        end
        next_st.sync = {st.sync[0], externalTimerClockPin};
        next_st.prev = st.sync[1];
        pinEdge = st.cfg.fallingEdge ? (st.prev && !st.sync[1])      // see RULE3
                                     : (!st.prev && st.sync[1]);
        next_st.cfg.wakeEnable          = !next_st.option[OPT_WAKE_BIT];   // see RULE1
        next_st.cfg.pullupEnable        = !next_st.option[OPT_PULLUP_BIT]; // see RULE1
        next_st.cfg.externalSource      = next_st.option[OPT_SOURCE_BIT];  // see RULE2
        next_st.cfg.fallingEdge         = next_st.option[OPT_EDGE_BIT];    // see RULE3
        next_st.cfg.prescalerToWatchdog = next_st.option[OPT_ASSIGN_BIT];  // see RULE4
        next_st.cfg.rate                = next_st.option[OPT_RATE_LSB +: 3];
        next_st.cfg.timerDivisor        = timer_divisor(next_st.cfg.rate);    // see RULE5
        next_st.cfg.watchdogDivisor     = watchdog_divisor(next_st.cfg.rate); // see RULE5
        // internal source counts each instruction cycle
        next_st.cfg.countPulse = st.cfg.externalSource ? pinEdge : 1'b1;  // see RULE2
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            // the synchroniser keeps following the pin, so release shows no false edge
            st <= '{option: OPTION_RESET, sync: next_st.sync, prev: next_st.prev,
                    cfg: '{wakeEnable: 1'b0, pullupEnable: 1'b0, externalSource: 1'b1,
                           fallingEdge: 1'b1, prescalerToWatchdog: 1'b1, rate: 3'h7,
                           timerDivisor: timer_divisor(3'h7),
                           watchdogDivisor: watchdog_divisor(3'h7), countPulse: 1'b0}};
        end else begin
            st <= next_st;
        end
    end

    assign cfg = st.cfg;

    property p_lowActive;
        @(posedge ref_clk) disable iff (srst)
        load |=> (cfg.wakeEnable == !$past(value[7])) && (cfg.pullupEnable == !$past(value[6]));
    endproperty
    a_lowActive: assert property (p_lowActive) else $error("enable bits not active low"); // see RULE1

    property p_source;
        @(posedge ref_clk) disable iff (srst)
        (!cfg.externalSource && !load) |=> cfg.countPulse;
    endproperty
    a_source: assert property (p_source) else $error("internal source missed a cycle"); // see RULE2

    sequence s_pinFall;
        st.sync[1] ##1 (!st.sync[1] && !load);
    endsequence

    property p_fallEdge;
        @(posedge ref_clk) disable iff (srst)
        (cfg.externalSource && cfg.fallingEdge && !load) ##0 s_pinFall |=> cfg.countPulse;
    endproperty
    a_fallEdge: assert property (p_fallEdge) else $error("falling edge not counted"); // see RULE3

    property p_assign;
        @(posedge ref_clk) disable iff (srst)
        load |=> cfg.prescalerToWatchdog == $past(value[3]);
    endproperty
    a_assign: assert property (p_assign) else $error("prescaler assignment wrong"); // see RULE4

    property p_rate;
        @(posedge ref_clk) disable iff (srst)
        load |=> (cfg.timerDivisor == (9'h002 << $past(value[2:0])))
              && (cfg.watchdogDivisor == (8'h01 << $past(value[2:0])));
    endproperty
    a_rate: assert property (p_rate) else $error("prescaler ratio wrong"); // see RULE5

    property p_optReset;
        @(posedge ref_clk)
        srst |=> (st.option == OPTION_RESET);
    endproperty
    a_optReset: assert property (p_optReset) else $error("option not all ones after reset"); // see RULE6

endmodule // timer_option_ctrl
